// file: grrb_checker_asserts.sv
// Port checker for the rate register bank.
`timescale 1ns/10ps
module grrb_checker import grrb_pkg::*; #(
    parameter logic [7:0] SENSOR_IDENTIFIER = 8'h5A,
    parameter int SOFT_RESET_DELAY = SOFT_RESET_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] rangeSelect,
    input wire logic [7:0] filterSelect,
    input wire logic [7:0] powerSelect,
    input wire logic softResetBusy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----
    // Decodes
    // ----
    wire logic rdDone = avs_read && !avs_waitrequest;
    wire logic wrDone = avs_write && !avs_waitrequest;
    wire logic keyWr = wrDone && avs_address == OFS_SOFT_RESET;
    wire logic resvHit = avs_address inside {8'h01, [8'h08:8'h09], [8'h0B:8'h0D],
        [8'h12:8'h13], 8'h17, [8'h19:8'h1D], [8'h1F:8'h33], [8'h35:8'h3B]};
    int busyCnt;
    // Length of the soft reset wait
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= softResetBusy ? busyCnt + 1 : 0;
        end
    end
    // ----
    // Properties
    // ----
    AST_WAIT_FIRST: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("new request without wait cycle");
    AST_ACK_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered after one wait");
    AST_ID_FIXED: assert property (rdDone && avs_address == OFS_IDENT
        |-> avs_readdata == {24'h000000, SENSOR_IDENTIFIER}) else $error("identifier wrong");
    AST_RESV_ZERO: assert property (rdDone && resvHit
        |-> avs_readdata == 32'h00000000) else $error("reserved read not zero");
    AST_RANGE_WR: assert property (wrDone && avs_address == OFS_RANGE && !softResetBusy
        |=> {24'h000000, rangeSelect} == ($past(avs_writedata) & 32'h000000FF))
        else $error("range write lost");
    AST_SR_START: assert property (keyWr && avs_writedata[7:0] == SOFT_RESET_KEY
        |=> softResetBusy) else $error("soft reset key not taken");
    AST_SR_OTHER: assert property (keyWr && avs_writedata[7:0] != SOFT_RESET_KEY
        && !softResetBusy |=> !softResetBusy) else $error("wrong key started reset");
    AST_SR_RESTORE: assert property ($fell(softResetBusy) |-> rangeSelect == RST_RANGE
        && filterSelect == RST_FILTER && powerSelect == RST_ZERO) else $error("config kept");
    AST_SR_LEN: assert property ($fell(softResetBusy) |-> busyCnt >= SOFT_RESET_DELAY - 1
        && busyCnt <= SOFT_RESET_DELAY + 1) else $error("soft reset wait length wrong");
    // Main scenarios reached
    cover property (rdDone && avs_address == OFS_X_LOW);
    cover property (rdDone && resvHit);
    cover property ($fell(softResetBusy));
endmodule
bind grrb_register_bank grrb_checker #(.SENSOR_IDENTIFIER(SENSOR_IDENTIFIER),
    .SOFT_RESET_DELAY(SOFT_RESET_DELAY)) checker0 (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rangeSelect(rangeSelect),
    .filterSelect(filterSelect), .powerSelect(powerSelect), .softResetBusy(softResetBusy));

// file: grrb_pkg.sv
// Package of register offsets, field positions, reset values and timing counts.
package grrb_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses on the bus)
    // ----------------------------------------
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_X_LOW = 8'h02;
    localparam logic [7:0] OFS_X_HIGH = 8'h03;
    localparam logic [7:0] OFS_Y_LOW = 8'h04;
    localparam logic [7:0] OFS_Y_HIGH = 8'h05;
    localparam logic [7:0] OFS_Z_LOW = 8'h06;
    localparam logic [7:0] OFS_Z_HIGH = 8'h07;
    localparam logic [7:0] OFS_INT_FLAGS = 8'h0A;
    localparam logic [7:0] OFS_QUEUE_STATE = 8'h0E;
    localparam logic [7:0] OFS_RANGE = 8'h0F;
    localparam logic [7:0] OFS_FILTER = 8'h10;
    localparam logic [7:0] OFS_POWER = 8'h11;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h14;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h15;
    localparam logic [7:0] OFS_PIN_CONFIG = 8'h16;
    localparam logic [7:0] OFS_PIN_ROUTING = 8'h18;
    localparam logic [7:0] OFS_LEVEL_IRQ_EN = 8'h1E;
    localparam logic [7:0] OFS_EXT_SYNC = 8'h34;
    localparam logic [7:0] OFS_BUILTIN_TEST = 8'h3C;
    localparam logic [7:0] OFS_QUEUE_LEVEL = 8'h3D;
    localparam logic [7:0] OFS_QUEUE_MODE = 8'h3E;
    localparam logic [7:0] OFS_QUEUE_PORT = 8'h3F;

    // ----------------------------------------
    // Reset values and fixed contents
    // ----------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RANGE = 8'h00;
    localparam logic [7:0] RST_FILTER = 8'h80;
    localparam logic [7:0] FILTER_RO_MASK = 8'h80;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;

    // ----------------------------------------
    // Built-in test field positions
    // ----------------------------------------
    localparam int BT_TRIG = 0;
    localparam int BT_READY = 1;
    localparam int BT_FAIL = 2;
    localparam int BT_RATE_OK = 4;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 40000000;
    localparam longint SOFT_RESET_MS = 30;
    localparam int SOFT_RESET_CYCLES = int'((SOFT_RESET_MS * CLK_HZ) / 1000);
    localparam int TEST_CYCLES = 16;
    localparam logic [23:0] CNT_ONE = 24'h000001;
    localparam logic [23:0] CNT_ZERO = 24'h000000;

    // Soft reset sequencer states
    typedef enum logic [1:0] {
        GRRB_SR_IDLE = 2'b01,
        GRRB_SR_WAIT = 2'b10
    } grrb_sr_state_t;

endpackage

// file: grrb_register_bank.sv
// Register bank of a three-axis rate sensor on an Avalon-MM slave.
`timescale 1ns/10ps
// What this block does
// - Identifier register at 0x00 is read-only fixed content; writes ignored.
// - Each axis rate is a signed 16-bit value in two byte registers.
// - X at 0x02/0x03, Y 0x04/0x05, Z 0x06/0x07; value = high*256+low.
// - Reading a low byte freezes its high byte until that high byte is read.
// - Range default 0x00: +/-32767 counts map to +/-2000 degrees per second.
// - Listed reserved addresses carry no function.
// - Self-test at 0x3C: trigger bit0, ready bit1, fail bit2, plausibility bit4.
// - Writing 0xB6 to soft reset restores configuration after 30 ms; others ignored.

// ----------------------------------------
// Register map
// ----------------------------------------
// 0x00 identifier, read-only
// 0x02 to 0x07 rate bytes, X then Y then Z
// 0x0A and 0x0E status, read as zero
// 0x0F range, 0x10 filter, 0x11 power mode
// 0x14 soft reset key, write-only
// 0x15, 0x16 and 0x18 interrupt setup
// 0x1E and 0x34 level interrupt enable and external sync
// 0x3C built-in test
// 0x3D and 0x3E queue setup
// 0x3F queue read port, reads zero
// Any other address reads zero and drops writes

// ----------------------------------------
// Bus timing
// ----------------------------------------
// Every access sees exactly one wait cycle
// Read data registered in that wait cycle
// Read data stand until the next read starts
// Back-to-back requests each get a wait cycle
// Only write data bits 7:0 are used
// Read data bits 31:8 are always zero

// ----------------------------------------
// Rate pairing
// ----------------------------------------
// A low byte read copies the matching high byte
// Copy taken on the edge that registers the low byte
// So a sample landing mid-read cannot split a pair
// A high byte read frees the copy again
// A repeated low byte read refreshes the copy

// ----------------------------------------
// Soft reset
// ----------------------------------------
// The key starts a long wait; other values are dropped
// Writes during the wait land, then are overwritten
// A second key during the wait is ignored
// Rates and pairing state are left alone
// Wait length is a parameter so a bench can shorten it

// ----------------------------------------
// Built-in test
// ----------------------------------------
// Writing bit 0 high starts a fixed-length run
// Bit 0 reads high while the run is busy
// Ready, fail and plausibility latch at its end
// A trigger during a run is ignored

// ----------------------------------------
// Reset
// ----------------------------------------
// rst resets every register at once
// Configuration takes its reset values
// Rates read zero until the first sample

// ----------------------------------------
// Limitations
// ----------------------------------------
// No interrupt, queue or power logic sits behind those bytes
// Self-test outcome comes from the sensing front end
// Full-scale scaling is done by the front end, not here

module grrb_register_bank import grrb_pkg::*; #(
    parameter logic [7:0] SENSOR_IDENTIFIER = 8'h5A, // Arbitrary identification value
    parameter int SOFT_RESET_DELAY = SOFT_RESET_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sampleValid,
    input wire logic [15:0] sampleX,
    input wire logic [15:0] sampleY,
    input wire logic [15:0] sampleZ,
    input wire logic testFail,
    input wire logic testRateOk,
    output logic [7:0] rangeSelect,
    output logic [7:0] filterSelect,
    output logic [7:0] powerSelect,
    output logic softResetBusy
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Live rate samples, one per axis
    logic [15:0] rateX;
    logic [15:0] rateY;
    logic [15:0] rateZ;

    // Frozen high bytes and their lock flags
    logic [7:0] heldHigh [3];
    logic [2:0] highLocked;

    // Configuration bytes with no logic behind them
    logic [7:0] intEnable;
    logic [7:0] pinConfig;
    logic [7:0] pinRouting;
    logic [7:0] levelIrqEn;
    logic [7:0] extSync;
    logic [7:0] queueLevel;
    logic [7:0] queueMode;

    // Built-in test run state
    logic testBusy;
    logic testReady;
    logic testFailFlag;
    logic testOkFlag;
    logic [4:0] testCount;

    // Soft reset sequencer
    grrb_sr_state_t srState;
    logic [23:0] srCount;

    // Answer cycle of the bus handshake
    logic ackPhase;

    // ----------------------------------------
    // Bus handshake: one wait cycle per access
    // ----------------------------------------
    wire logic accessReq = avs_read | avs_write;
    // Read data capture edge, then the answer strobes
    wire logic rdTake = avs_read & ~ackPhase;
    wire logic wrStrobe = avs_write & ackPhase;
    wire logic rdStrobe = avs_read & ackPhase;
    assign avs_waitrequest = accessReq & ~ackPhase;

    // Decode helper for strobes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Write side decodes
    wire logic [7:0] wrByte = avs_writedata[7:0];
    wire logic wrSoftReset = wrStrobe & hit(avs_address, OFS_SOFT_RESET);
    wire logic softKey = wrSoftReset & (wrByte == SOFT_RESET_KEY);
    wire logic wrTest = wrStrobe & hit(avs_address, OFS_BUILTIN_TEST) & wrByte[BT_TRIG];

    // Last cycle of the soft reset wait
    wire logic srDone = (srState == GRRB_SR_WAIT) & (srCount == CNT_ONE);

    // Low reads lock on the capture edge, so both bytes share a sample
    wire logic [2:0] rdLow = {rdTake & hit(avs_address, OFS_Z_LOW),
                              rdTake & hit(avs_address, OFS_Y_LOW),
                              rdTake & hit(avs_address, OFS_X_LOW)};

    // High reads unlock on the answer edge
    wire logic [2:0] rdHigh = {rdStrobe & hit(avs_address, OFS_Z_HIGH),
                               rdStrobe & hit(avs_address, OFS_Y_HIGH),
                               rdStrobe & hit(avs_address, OFS_X_HIGH)};
    wire logic [15:0] rateAll [3] = '{rateX, rateY, rateZ};

    // High byte seen by software: frozen copy while locked
    wire logic [7:0] highX = highLocked[0] ? heldHigh[0] : rateX[15:8];
    wire logic [7:0] highY = highLocked[1] ? heldHigh[1] : rateY[15:8];
    wire logic [7:0] highZ = highLocked[2] ? heldHigh[2] : rateZ[15:8];

    // Built-in test layout
    wire logic [7:0] testView = {3'b000, testOkFlag, 1'b0, testFailFlag, testReady,
                                 testBusy};

    // ----------------------------------------
    // Read multiplexer; unmapped reads give zero
    // ----------------------------------------
    logic [7:0] rdByte;
    always_comb begin
        case (avs_address)
            OFS_IDENT: rdByte = SENSOR_IDENTIFIER;
            OFS_X_LOW: rdByte = rateX[7:0];
            OFS_X_HIGH: rdByte = highX;
            OFS_Y_LOW: rdByte = rateY[7:0];
            OFS_Y_HIGH: rdByte = highY;
            OFS_Z_LOW: rdByte = rateZ[7:0];
            OFS_Z_HIGH: rdByte = highZ;
            // Status bytes with no logic behind them
            OFS_INT_FLAGS: rdByte = RST_ZERO;
            OFS_QUEUE_STATE: rdByte = RST_ZERO;
            // Configuration read back
            OFS_RANGE: rdByte = rangeSelect;
            OFS_FILTER: rdByte = filterSelect;
            OFS_POWER: rdByte = powerSelect;
            OFS_INT_ENABLE: rdByte = intEnable;
            OFS_PIN_CONFIG: rdByte = pinConfig;
            OFS_PIN_ROUTING: rdByte = pinRouting;
            OFS_LEVEL_IRQ_EN: rdByte = levelIrqEn;
            OFS_EXT_SYNC: rdByte = extSync;
            OFS_BUILTIN_TEST: rdByte = testView;
            OFS_QUEUE_LEVEL: rdByte = queueLevel;
            OFS_QUEUE_MODE: rdByte = queueMode;
            default: rdByte = RST_ZERO;
        endcase
    end

    // ----------------------------------------
    // Bus answer phase and read data register
    // ----------------------------------------
    // High only in the cycle where waitrequest is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ackPhase <= 1'b0;
        end else begin
            ackPhase <= accessReq & ~ackPhase;
        end
    end

    // Read data registered in the wait cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (rdTake) begin
            avs_readdata <= {24'h000000, rdByte};
        end
    end

    // ----------------------------------------
    // Live sample capture (signed 16-bit per axis)
    // ----------------------------------------
    // Taken only while the front end flags a sample
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rateX <= 16'h0000;
            rateY <= 16'h0000;
            rateZ <= 16'h0000;
        end else if (sampleValid) begin
            rateX <= sampleX;
            rateY <= sampleY;
            rateZ <= sampleZ;
        end
    end

    // ----------------------------------------
    // High byte lock: set on low read, freed on high read
    // ----------------------------------------
    // The copy is taken from the live rate, not the view
    // Reset leaves every axis unlocked
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            highLocked <= 3'b000;
            heldHigh <= '{8'h00, 8'h00, 8'h00};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (rdLow[i]) begin
                    highLocked[i] <= 1'b1;
                    heldHigh[i] <= rateAll[i][15:8];
                end else if (rdHigh[i]) begin
                    highLocked[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Soft reset sequencer: wait then restore config
    // ----------------------------------------
    // Counts down from the delay; the last count restores
    // A key seen while waiting is ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            srState <= GRRB_SR_IDLE;
            srCount <= CNT_ZERO;
        end else begin
            case (srState)
                GRRB_SR_IDLE: begin
                    if (softKey) begin
                        srState <= GRRB_SR_WAIT;
                        srCount <= SOFT_RESET_DELAY[23:0];
                    end
                end
                GRRB_SR_WAIT: begin
                    if (srDone) begin
                        srState <= GRRB_SR_IDLE;
                        srCount <= CNT_ZERO;
                    end else begin
                        srCount <= srCount - CNT_ONE;
                    end
                end
                default: begin
                    srState <= GRRB_SR_IDLE;
                    srCount <= CNT_ZERO;
                end
            endcase
        end
    end
    assign softResetBusy = (srState == GRRB_SR_WAIT);

    // ----------------------------------------
    // Configuration registers; soft reset restores them
    // ----------------------------------------
    // Restore wins over a write in the same cycle
    // Filter bit 7 always reads one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rangeSelect <= RST_RANGE;
            filterSelect <= RST_FILTER;
            powerSelect <= RST_ZERO;
            intEnable <= RST_ZERO;
            pinConfig <= RST_ZERO;
            pinRouting <= RST_ZERO;
            levelIrqEn <= RST_ZERO;
            extSync <= RST_ZERO;
            queueLevel <= RST_ZERO;
            queueMode <= RST_ZERO;
        end else if (srDone) begin
            rangeSelect <= RST_RANGE;
            filterSelect <= RST_FILTER;
            powerSelect <= RST_ZERO;
            intEnable <= RST_ZERO;
            pinConfig <= RST_ZERO;
            pinRouting <= RST_ZERO;
            levelIrqEn <= RST_ZERO;
            extSync <= RST_ZERO;
            queueLevel <= RST_ZERO;
            queueMode <= RST_ZERO;
        end else if (wrStrobe) begin
            case (avs_address)
                OFS_RANGE: rangeSelect <= wrByte;
                OFS_FILTER: filterSelect <= wrByte | FILTER_RO_MASK;
                OFS_POWER: powerSelect <= wrByte;
                OFS_INT_ENABLE: intEnable <= wrByte;
                OFS_PIN_CONFIG: pinConfig <= wrByte;
                OFS_PIN_ROUTING: pinRouting <= wrByte;
                OFS_LEVEL_IRQ_EN: levelIrqEn <= wrByte;
                OFS_EXT_SYNC: extSync <= wrByte;
                OFS_QUEUE_LEVEL: queueLevel <= wrByte;
                OFS_QUEUE_MODE: queueMode <= wrByte;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Built-in test: trigger runs a short sequence
    // ----------------------------------------
    // Fail and plausibility are latched on the last count
    // Ready clears when a new run starts
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            testBusy <= 1'b0;
            testReady <= 1'b0;
            testFailFlag <= 1'b0;
            testOkFlag <= 1'b0;
            testCount <= 5'h00;
        end else if (wrTest & ~testBusy) begin
            testBusy <= 1'b1;
            testReady <= 1'b0;
            testCount <= 5'(TEST_CYCLES);
        end else if (testBusy) begin
            if (testCount == 5'h01) begin
                testBusy <= 1'b0;
                testReady <= 1'b1;
                testFailFlag <= testFail;
                testOkFlag <= testRateOk;
            end
            testCount <= testCount - 5'h01;
        end
    end

endmodule

// file: grrb_register_bank_bench.sv
// Self-checking bench for the rate register bank.
`timescale 1ns/10ps
module grrb_register_bank_bench import grrb_pkg::*; ;
    localparam logic [7:0] ID_VALUE = 8'hA5; // Arbitrary identification value
    localparam logic [15:0] SA[3] = '{16'h7FFF, 16'h8001, 16'h0000};
    localparam logic [15:0] SB[3] = '{16'h1234, 16'h5678, 16'h9ABC};
    localparam logic [7:0] RESV[15] = '{8'h01, 8'h08, 8'h09, 8'h0B, 8'h0D, 8'h12, 8'h13,
        8'h14, 8'h17, 8'h19, 8'h1D, 8'h1F, 8'h33, 8'h35, 8'h3B};
    localparam logic [7:0] CFG[7] = '{OFS_INT_ENABLE, OFS_PIN_CONFIG, OFS_PIN_ROUTING,
        OFS_LEVEL_IRQ_EN, OFS_EXT_SYNC, OFS_QUEUE_LEVEL, OFS_QUEUE_MODE};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, sampleValid, testFail, testRateOk, softResetBusy;
    logic [15:0] sampleX, sampleY, sampleZ;
    logic [7:0] rangeSelect, filterSelect, powerSelect;
    logic load = 1'b0;
    logic faultMode = 1'b0;
    logic [15:0] nextS[3] = '{16'h0000, 16'h0000, 16'h0000};
    int errors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    always #12.5 mclk = ~mclk;
    grrb_register_bank #(.SENSOR_IDENTIFIER(ID_VALUE), .SOFT_RESET_DELAY(20)) DUT (.mclk(mclk),
        .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sampleValid(sampleValid), .sampleX(sampleX),
        .sampleY(sampleY), .sampleZ(sampleZ), .testFail(testFail), .testRateOk(testRateOk),
        .rangeSelect(rangeSelect), .filterSelect(filterSelect), .powerSelect(powerSelect),
        .softResetBusy(softResetBusy));
    grrb_sample_source farEnd (.mclk(mclk), .rst(rst), .load(load), .faultMode(faultMode),
        .nextX(nextS[0]), .nextY(nextS[1]), .nextZ(nextS[2]), .sampleValid(sampleValid),
        .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ), .testFail(testFail),
        .testRateOk(testRateOk));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        chk(avs_readdata, {24'h000000, exp});
        avs_read <= 1'b0;
    endtask
    task automatic putSample(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge mclk);
        nextS <= '{x, y, z};
        load <= 1'b1;
        @(posedge mclk);
        load <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        logic [7:0] lo;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rdChk(OFS_IDENT, ID_VALUE);
        busWrite(OFS_IDENT, 8'hFF);
        rdChk(OFS_IDENT, ID_VALUE);
        foreach (RESV[i]) begin
            busWrite(RESV[i], 8'hFF);
            rdChk(RESV[i], 8'h00);
        end
        rdChk(OFS_RANGE, RST_RANGE);
        rdChk(OFS_POWER, RST_ZERO);
        busWrite(OFS_FILTER, 8'h05);
        rdChk(OFS_FILTER, 8'h85);
        for (int i = 0; i < 3; i++) begin
            lo = OFS_X_LOW + 8'(2 * i);
            putSample(SA[0], SA[1], SA[2]);
            rdChk(lo, SA[i][7:0]);
            putSample(SB[0], SB[1], SB[2]);
            rdChk(lo + 8'h01, SA[i][15:8]);
            rdChk(lo + 8'h01, SB[i][15:8]);
            rdChk(lo, SB[i][7:0]);
            rdChk(lo + 8'h01, SB[i][15:8]);
        end
        busWrite(OFS_RANGE, 8'h03);
        busWrite(OFS_POWER, 8'h80);
        rdChk(OFS_RANGE, 8'h03);
        rdChk(OFS_POWER, 8'h80);
        foreach (CFG[i]) begin
            busWrite(CFG[i], 8'hC3);
            rdChk(CFG[i], 8'hC3);
        end
        busWrite(OFS_SOFT_RESET, 8'h55);
        @(negedge mclk);
        chk({31'h0, softResetBusy}, 32'h00000000);
        busWrite(OFS_SOFT_RESET, SOFT_RESET_KEY);
        @(negedge mclk);
        chk({31'h0, softResetBusy}, 32'h00000001);
        rdChk(OFS_RANGE, 8'h03);
        for (int n = 0; n < 40 && softResetBusy; n++) @(negedge mclk);
        chk({8'h00, rangeSelect, filterSelect, powerSelect}, 32'h00008000);
        rdChk(OFS_RANGE, RST_RANGE);
        foreach (CFG[i]) begin
            rdChk(CFG[i], RST_ZERO);
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge mclk);
            faultMode <= f[0];
            busWrite(OFS_BUILTIN_TEST, 8'h01);
            repeat (TEST_CYCLES + 4) @(posedge mclk);
            rdChk(OFS_BUILTIN_TEST, {3'b000, ~f[0], 1'b0, f[0], 2'b10});
        end
        results();
    end
endmodule

// file: grrb_sample_source.sv
// Behavioural rate front end that feeds samples to the bank.
`timescale 1ns/10ps
module grrb_sample_source (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic faultMode,
    input wire logic [15:0] nextX,
    input wire logic [15:0] nextY,
    input wire logic [15:0] nextZ,
    output logic sampleValid,
    output logic [15:0] sampleX,
    output logic [15:0] sampleY,
    output logic [15:0] sampleZ,
    output logic testFail,
    output logic testRateOk
);
    // One-cycle sample, lines scrambled between samples
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sampleValid <= 1'b0;
            sampleX <= 16'h0000;
            sampleY <= 16'h0000;
            sampleZ <= 16'h0000;
        end else begin
            sampleValid <= load;
            sampleX <= load ? nextX : ~sampleX;
            sampleY <= load ? nextY : ~sampleY;
            sampleZ <= load ? nextZ : ~sampleZ;
        end
    end
    // Self-test outcome
    assign testFail = faultMode;
    assign testRateOk = !faultMode;
endmodule
